// [cb_cfg.svh]
// offsets, field positions, reset values and masks of the core register bank
// assumes it is included by bare name into every file that decodes registers
`ifndef CB_CFG_SVH
`define CB_CFG_SVH

// ************************************************************
// register offsets (byte address on the bus is four times these)
// ************************************************************
`define CB_A_IND_PORT   8'h80
`define CB_A_OPTION     8'h81
`define CB_A_PC_LOW     8'h82
`define CB_A_FLAGS      8'h83
`define CB_A_POINTER    8'h84
`define CB_A_DIR_A      8'h85
`define CB_A_DIR_B      8'h86
`define CB_A_PC_HIGH    8'h8A
`define CB_A_INT_CTRL   8'h8B
`define CB_A_IRQ_EN1    8'h8C
`define CB_A_PWR_FLAGS  8'h8E
`define CB_A_T2_PERIOD  8'h92
`define CB_A_ADC_CFG1   8'h9F

// ************************************************************
// general purpose memory windows
// ************************************************************
`define CB_GPR0_LO      7'h20
`define CB_SHARED_LO    8'hF0
`define CB_GPR1_LO      8'hA0
`define CB_GPR1_HI      8'hBF
`define CB_GPR1_BASE    7'h60

// ************************************************************
// implemented-bit masks and reset values
// ************************************************************
`define CB_M_DIR_A      8'h1F
`define CB_M_PC_HIGH    8'h1F
`define CB_M_IRQ_EN1    8'h47
`define CB_M_PWR_FLAGS  8'h03
`define CB_M_ADC_CFG1   8'h07
`define CB_R_ALL_ONES   8'hFF
`define CB_R_ZERO       8'h00
`define CB_R_FLAGS_PWR  8'h18
`define CB_PWR_POR_BIT  1
`define CB_PWR_BOR_BIT  0

// ************************************************************
// core flag bit positions
// ************************************************************
`define CB_ST_CARRY     0
`define CB_ST_NIBBLE    1
`define CB_ST_ZERO      2
`define CB_ST_SLEEP     3
`define CB_ST_TIMEOUT   4
`define CB_ST_BANK      5

`define CB_RESP_OKAY    2'h0

`endif

// [cb_pkg.sv]
// types shared by the core register bank modules
// assumes nothing beyond a SystemVerilog compiler
package cb_pkg;
    typedef logic [7:0] cb_byte_t;
    typedef enum logic [1:0] {
        CB_RST_NONE,
        CB_RST_OTHER,
        CB_RST_POWER
    } cb_rst_kind_t;
endpackage

// [cb_gpr.sv]
// general purpose data memory held in flip-flops
// assumes one write and one combinational read port, indices in range
`timescale 1ns/1ps
`default_nettype none
module cb_gpr
    import cb_pkg::*;
#(
    parameter int DEPTH = 128,
    parameter int IDX_W = 7
) (
    // clock
    input  wire logic             aclk,
    // write port
    input  wire logic             we,
    input  wire logic [IDX_W-1:0] wr_idx,
    input  wire cb_byte_t         wr_data,
    // read port
    input  wire logic [IDX_W-1:0] rd_idx,
    output cb_byte_t              rd_data
);
    initial begin
        if (DEPTH > (1 << IDX_W) || DEPTH < 1) begin
            $error("cb_gpr: depth does not fit the index width");
        end
    end

    cb_byte_t mem [DEPTH];

    // no reset: power-up contents are undefined, as in ordinary data memory
    always_ff @(posedge aclk) begin
        if (we) begin
            mem[wr_idx] <= wr_data;
        end
    end

    assign rd_data = mem[rd_idx];
endmodule
`default_nettype wire

// [cb_flags.sv]
// core flag register: arithmetic flags, timeout and sleep flags, bank bits
// assumes event inputs are synchronous single-cycle pulses from the core
`timescale 1ns/1ps
`default_nettype none
`include "cb_cfg.svh"
module cb_flags
    import cb_pkg::*;
(
    // clock and reset kind
    input  wire logic         aclk,
    input  wire cb_rst_kind_t rst_kind,
    input  wire logic         rst_wdt,
    // software write
    input  wire logic         wr_en,
    input  wire cb_byte_t     wr_data,
    // arithmetic results
    input  wire logic         alu_zero_we,
    input  wire logic         alu_zero,
    input  wire logic         alu_nibble_we,
    input  wire logic         alu_nibble_carry,
    input  wire logic         alu_carry_we,
    input  wire logic         alu_carry,
    input  wire logic         alu_sub,
    // power events
    input  wire logic         wdt_clear,
    input  wire logic         sleep_enter,
    // state
    output cb_byte_t          flags
);
    logic       alu_any;
    logic [7:5] bank_bits;
    logic       timeout_flag;
    logic       sleep_flag;
    logic [2:0] arith_bits;

    assign alu_any = alu_zero_we | alu_nibble_we | alu_carry_we;
    // one process owns each field, so no bit of the image has two drivers
    assign flags   = {bank_bits, timeout_flag, sleep_flag, arith_bits};

    // ************************************************************
    // bank and reserved bits, software writable
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (rst_kind != CB_RST_NONE) begin
            bank_bits <= 3'h0;
        end else if (wr_en) begin
            bank_bits <= wr_data[7:5];
        end
    end

    // ************************************************************
    // timeout and sleep flags: no software path reaches them
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (rst_kind == CB_RST_POWER) begin
            timeout_flag <= 1'b1;
            sleep_flag   <= 1'b1;
        end else if (rst_wdt) begin
            timeout_flag <= 1'b0;
        end else if (wdt_clear) begin
            timeout_flag <= 1'b1;
            sleep_flag   <= 1'b1;
        end else if (sleep_enter) begin
            timeout_flag <= 1'b1;
            sleep_flag   <= 1'b0;
        end
    end

    // ************************************************************
    // arithmetic flags: flag logic beats a software write
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (alu_any) begin
            if (alu_zero_we) begin
                arith_bits[`CB_ST_ZERO] <= alu_zero;
            end
            if (alu_nibble_we) begin
                arith_bits[`CB_ST_NIBBLE] <= alu_nibble_carry ^ alu_sub;
            end
            if (alu_carry_we) begin
                arith_bits[`CB_ST_CARRY] <= alu_carry ^ alu_sub;
            end
        end else if (wr_en) begin
            arith_bits <= wr_data[2:0];
        end
    end
endmodule
`default_nettype wire

// [cb_bank.sv]
// core register bank of a small 8-bit controller, reached over AXI4-Lite
// assumes core event inputs are synchronous to aclk and one cycle long
// Summary of operation
// - pointer, pc low, flags, pc high latch, interrupt control mirrored in both banks
// - pc upper byte not readable; latch supplies pc bits 12:8 on pc load
// - pin reset and watchdog reset are other resets, unlike power and brown-out
// - every reset sets all port direction bits to one
// - unimplemented addresses and bits read back as zero
// - flag logic result beats a software write of zero, nibble and carry flags
// - timeout and sleep flags ignore software writes
// - clearing the flag register zeroes its upper three bits and the zero flag
// - carry and nibble flags are inverted borrows during subtraction
// - flag layout: arithmetic 2:0, timeout 4, sleep 3 set at power reset, bank 5
// - power or brown-out reset loads option and period with ones, pc low zero
// - bank bit picks the upper or lower half for direct addressing
//
// The implementer's own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cb_cfg.svh"
module cb_bank
    import cb_pkg::*;
#(
    parameter int ADDR_W    = 10,
    parameter int GPR_DEPTH = 128
) (
    // clock and bus reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // write address channel
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // write data channel
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // write response channel
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // read address channel
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // read data channel
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // reset sources
    input  wire logic              power_on_pulse,
    input  wire logic              brown_out_pulse,
    input  wire logic              external_reset_pin,
    input  wire logic              wdt_timeout,
    // flag logic from the instruction datapath
    input  wire logic              alu_zero_we,
    input  wire logic              alu_zero,
    input  wire logic              alu_nibble_we,
    input  wire logic              alu_nibble_carry,
    input  wire logic              alu_carry_we,
    input  wire logic              alu_carry,
    input  wire logic              alu_sub,
    input  wire logic              wdt_clear,
    input  wire logic              sleep_enter,
    // register contents to the core and peripherals
    output logic [12:0]            pc_value,
    output logic                   pc_load,
    output cb_byte_t               core_flags,
    output cb_byte_t               option_config,
    output logic [4:0]             port_a_direction,
    output cb_byte_t               port_b_direction,
    output cb_byte_t               interrupt_control,
    output cb_byte_t               peripheral_irq_enable_1,
    output logic [1:0]             power_reset_flags,
    output cb_byte_t               timer2_period,
    output logic [2:0]             adc_config_1
);
    initial begin
        if (ADDR_W < 10) begin
            $error("cb_bank: address width too small for the register map");
        end
        if (GPR_DEPTH != 128) begin
            $error("cb_bank: data memory map needs exactly 128 locations");
        end
    end

    // ************************************************************
    // address decode helpers
    // ************************************************************
    function automatic logic is_core(input logic [6:0] low);
        logic [7:0] a;
        a = {1'b1, low};
        return a == `CB_A_IND_PORT || a == `CB_A_PC_LOW || a == `CB_A_FLAGS
            || a == `CB_A_POINTER || a == `CB_A_PC_HIGH || a == `CB_A_INT_CTRL;
    endfunction

    // returns {valid, absolute address}; indirect port is chased once
    function automatic logic [8:0] resolve(input logic [7:0] idx, input logic bank,
                                           input cb_byte_t ptr);
        logic [7:0] a;
        a = idx[7] ? idx : {bank, idx[6:0]};
        if (is_core(a[6:0])) begin
            a[7] = 1'b1;
        end
        if (a == `CB_A_IND_PORT) begin
            a = ptr;
            if (is_core(a[6:0])) begin
                a[7] = 1'b1;
            end
        end
        // pointing the pointer at the port itself reaches nothing
        return {a != `CB_A_IND_PORT, a};
    endfunction

    // returns {hit, index} into general purpose memory
    function automatic logic [7:0] gpr_index(input logic [7:0] a);
        if ((!a[7] || a >= `CB_SHARED_LO) && a[6:0] >= `CB_GPR0_LO) begin
            return {1'b1, a[6:0] - `CB_GPR0_LO};
        end
        if (a >= `CB_GPR1_LO && a <= `CB_GPR1_HI) begin
            return {1'b1, 7'(a - `CB_GPR1_LO + {1'b0, `CB_GPR1_BASE})};
        end
        return 8'h00;
    endfunction

    // ************************************************************
    // reset kinds
    // ************************************************************
    cb_rst_kind_t rst_kind;
    always_comb begin
        if (!aresetn || power_on_pulse || brown_out_pulse) begin
            rst_kind = CB_RST_POWER;
        end else if (external_reset_pin || wdt_timeout) begin
            rst_kind = CB_RST_OTHER;
        end else begin
            rst_kind = CB_RST_NONE;
        end
    end

    // ************************************************************
    // write channel capture
    // ************************************************************
    logic              aw_full;
    logic              w_full;
    logic [ADDR_W-1:0] aw_addr;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              commit;

    assign s_axi_awready = !aw_full;
    assign s_axi_wready  = !w_full;
    assign commit        = aw_full && w_full && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && !aw_full) begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (commit) begin
            aw_full <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full <= 1'b0;
            w_data <= '0;
            w_strb <= '0;
        end else if (s_axi_wvalid && !w_full) begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end else if (commit) begin
            w_full <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
        end else if (commit) begin
            s_axi_bvalid <= 1'b1;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
    // unmapped writes are dropped silently, so every answer is OKAY
    assign s_axi_bresp = `CB_RESP_OKAY;

    // ************************************************************
    // write target
    // ************************************************************
    cb_byte_t   pointer;
    logic [8:0] wr_res;
    logic [7:0] wr_gpr;
    logic       wr_ok;
    cb_byte_t   wr_byte;

    assign wr_res  = resolve(aw_addr[9:2], core_flags[`CB_ST_BANK], pointer);
    assign wr_gpr  = gpr_index(wr_res[7:0]);
    assign wr_ok   = commit && w_strb[0] && wr_res[8];
    assign wr_byte = w_data[7:0];

    function automatic logic wr_hit(input logic ok, input logic [7:0] a,
                                    input logic [7:0] target);
        return ok && a == target;
    endfunction

    // ************************************************************
    // program counter and its high latch
    // ************************************************************
    logic [4:0] pc_high_latch;

    always_ff @(posedge aclk) begin
        if (rst_kind != CB_RST_NONE) begin
            pc_high_latch <= '0;
        end else if (wr_hit(wr_ok, wr_res[7:0], `CB_A_PC_HIGH)) begin
            pc_high_latch <= wr_byte[4:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (rst_kind != CB_RST_NONE) begin
            pc_value <= '0;
            pc_load  <= 1'b0;
        end else if (wr_hit(wr_ok, wr_res[7:0], `CB_A_PC_LOW)) begin
            pc_value <= {pc_high_latch, wr_byte};
            pc_load  <= 1'b1;
        end else begin
            pc_load  <= 1'b0;
        end
    end

    // ************************************************************
    // plain control registers
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (rst_kind != CB_RST_NONE) begin
            port_a_direction <= 5'(`CB_M_DIR_A);
            port_b_direction <= `CB_R_ALL_ONES;
        end else begin
            if (wr_hit(wr_ok, wr_res[7:0], `CB_A_DIR_A)) begin
                port_a_direction <= wr_byte[4:0];
            end
            if (wr_hit(wr_ok, wr_res[7:0], `CB_A_DIR_B)) begin
                port_b_direction <= wr_byte;
            end
        end
    end

    // other resets leave option and period untouched
    always_ff @(posedge aclk) begin
        if (rst_kind == CB_RST_POWER) begin
            option_config <= `CB_R_ALL_ONES;
            timer2_period <= `CB_R_ALL_ONES;
        end else begin
            if (wr_hit(wr_ok, wr_res[7:0], `CB_A_OPTION)) begin
                option_config <= wr_byte;
            end
            if (wr_hit(wr_ok, wr_res[7:0], `CB_A_T2_PERIOD)) begin
                timer2_period <= wr_byte;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (rst_kind != CB_RST_NONE) begin
            interrupt_control       <= `CB_R_ZERO;
            peripheral_irq_enable_1 <= `CB_R_ZERO;
            adc_config_1            <= '0;
        end else begin
            if (wr_hit(wr_ok, wr_res[7:0], `CB_A_INT_CTRL)) begin
                interrupt_control <= wr_byte;
            end
            if (wr_hit(wr_ok, wr_res[7:0], `CB_A_IRQ_EN1)) begin
                peripheral_irq_enable_1 <= wr_byte & `CB_M_IRQ_EN1;
            end
            if (wr_hit(wr_ok, wr_res[7:0], `CB_A_ADC_CFG1)) begin
                adc_config_1 <= wr_byte[2:0];
            end
        end
    end

    // pointer has no defined reset value; cleared on power-up for determinism
    always_ff @(posedge aclk) begin
        if (rst_kind == CB_RST_POWER) begin
            pointer <= `CB_R_ZERO;
        end else if (wr_hit(wr_ok, wr_res[7:0], `CB_A_POINTER)) begin
            pointer <= wr_byte;
        end
    end

    // hardware clearing of a power flag wins over a software set
    always_ff @(posedge aclk) begin
        if (!aresetn || power_on_pulse) begin
            power_reset_flags <= '0;
        end else if (brown_out_pulse) begin
            power_reset_flags[`CB_PWR_BOR_BIT] <= 1'b0;
        end else if (wr_hit(wr_ok, wr_res[7:0], `CB_A_PWR_FLAGS)) begin
            power_reset_flags <= wr_byte[1:0];
        end
    end

    // ************************************************************
    // core flags and data memory
    // ************************************************************
    cb_flags u_flags (
        .aclk             (aclk),
        .rst_kind         (rst_kind),
        .rst_wdt          (wdt_timeout),
        .wr_en            (wr_hit(wr_ok, wr_res[7:0], `CB_A_FLAGS)),
        .wr_data          (wr_byte),
        .alu_zero_we      (alu_zero_we),
        .alu_zero         (alu_zero),
        .alu_nibble_we    (alu_nibble_we),
        .alu_nibble_carry (alu_nibble_carry),
        .alu_carry_we     (alu_carry_we),
        .alu_carry        (alu_carry),
        .alu_sub          (alu_sub),
        .wdt_clear        (wdt_clear),
        .sleep_enter      (sleep_enter),
        .flags            (core_flags)
    );

    logic [8:0] rd_res;
    logic [7:0] rd_gpr;
    cb_byte_t   gpr_rd_data;

    cb_gpr #(
        .DEPTH (GPR_DEPTH),
        .IDX_W (7)
    ) u_gpr (
        .aclk    (aclk),
        .we      (wr_ok && wr_gpr[7]),
        .wr_idx  (wr_gpr[6:0]),
        .wr_data (wr_byte),
        .rd_idx  (rd_gpr[6:0]),
        .rd_data (gpr_rd_data)
    );

    // ************************************************************
    // read path
    // ************************************************************
    assign rd_res = resolve(s_axi_araddr[9:2], core_flags[`CB_ST_BANK], pointer);
    assign rd_gpr = gpr_index(rd_res[7:0]);

    cb_byte_t rd_byte;
    always_comb begin
        rd_byte = `CB_R_ZERO;
        if (rd_gpr[7]) begin
            rd_byte = gpr_rd_data;
        end else if (rd_res[8]) begin
            unique case (rd_res[7:0])
                `CB_A_OPTION:    rd_byte = option_config;
                `CB_A_PC_LOW:    rd_byte = pc_value[7:0];
                `CB_A_FLAGS:     rd_byte = core_flags;
                `CB_A_POINTER:   rd_byte = pointer;
                `CB_A_DIR_A:     rd_byte = {3'h0, port_a_direction};
                `CB_A_DIR_B:     rd_byte = port_b_direction;
                `CB_A_PC_HIGH:   rd_byte = {3'h0, pc_high_latch};
                `CB_A_INT_CTRL:  rd_byte = interrupt_control;
                `CB_A_IRQ_EN1:   rd_byte = peripheral_irq_enable_1;
                `CB_A_PWR_FLAGS: rd_byte = {6'h00, power_reset_flags};
                `CB_A_T2_PERIOD: rd_byte = timer2_period;
                `CB_A_ADC_CFG1:  rd_byte = {5'h00, adc_config_1};
                default:         rd_byte = `CB_R_ZERO;
            endcase
        end
    end

    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rresp   = `CB_RESP_OKAY;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= '0;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h000000, rd_byte};
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// [cb_bank_assertions.sv]
// checker for the core register bank: reset, flag and read-back relations
// assumes it is bound to cb_bank and sees only the ports of that module
`timescale 1ns/1ps
`default_nettype none
module cb_bank_chk
    import cb_pkg::*;
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // bus read side
    input wire logic        s_axi_rvalid,
    input wire logic [31:0] s_axi_rdata,
    // core events
    input wire logic        power_on_pulse,
    input wire logic        external_reset_pin,
    input wire logic        wdt_timeout,
    input wire logic        alu_carry_we,
    input wire logic        alu_carry,
    input wire logic        alu_sub,
    input wire logic        alu_zero_we,
    input wire logic        alu_zero,
    // register images
    input wire cb_byte_t    core_flags,
    input wire cb_byte_t    option_config,
    input wire cb_byte_t    timer2_period,
    input wire cb_byte_t    port_b_direction,
    input wire logic [4:0]  port_a_direction,
    input wire logic [12:0] pc_value,
    input wire logic        pc_load
);
// ****
// relations
// ****
default clocking @(posedge aclk); endclocking
default disable iff (!aresetn);
property p_rd_hi; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
a_rd_hi: assert property (p_rd_hi) else $error("read data upper lanes not zero");
property p_dir; external_reset_pin || wdt_timeout |=> port_b_direction == 8'hFF
    && port_a_direction == 5'h1F; endproperty
a_dir: assert property (p_dir) else $error("directions not all inputs after reset");
property p_pin; external_reset_pin |=> core_flags[7:5] == 3'h0; endproperty
a_pin: assert property (p_pin) else $error("pin reset left bank bits");
property p_por; power_on_pulse |=> option_config == 8'hFF && timer2_period == 8'hFF
    && pc_value[7:0] == 8'h00; endproperty
a_por: assert property (p_por) else $error("power reset values wrong");
property p_por_fl; power_on_pulse |=> core_flags[4:3] == 2'b11; endproperty
a_por_fl: assert property (p_por_fl) else $error("timeout or sleep flag not set");
property p_borrow; alu_carry_we && alu_sub |=> core_flags[0] == !$past(alu_carry); endproperty
a_borrow: assert property (p_borrow) else $error("carry not inverted borrow");
property p_zero; alu_zero_we |=> core_flags[2] == $past(alu_zero); endproperty
a_zero: assert property (p_zero) else $error("zero flag not from flag logic");
property p_wdt; wdt_timeout |=> !core_flags[4]; endproperty
a_wdt: assert property (p_wdt) else $error("timeout flag not cleared");
property p_pcl; pc_load |=> !pc_load; endproperty
a_pcl: assert property (p_pcl) else $error("pc load not a single pulse");
endmodule
bind cb_bank cb_bank_chk u_chk (.*);
`default_nettype wire

// [core_status_and_bank1_sfr_map_tb_top.sv]
// bench for the core register bank, driving the bus and core events itself
// assumes cb_bank with a 10-bit byte address, index times four on the bus
`timescale 1ns/1ps
`default_nettype none
module core_status_and_bank1_sfr_map_tb_top
    import cb_pkg::*;
;
// response readies stay high, so back-to-back calls never re-raise them in one step
logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 1;
logic s_axi_arvalid = 0, s_axi_rready = 1, s_axi_awready, s_axi_wready, s_axi_bvalid;
logic s_axi_arready, s_axi_rvalid, pc_load, brown_out_pulse = 0, alu_nibble_we = 0;
logic alu_nibble_carry = 0, wdt_clear = 0, power_on_pulse, external_reset_pin, wdt_timeout;
logic sleep_enter, alu_carry_we, alu_sub, alu_carry, alu_zero_we, alu_zero;
logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
logic [31:0] s_axi_wdata = 0, s_axi_rdata;
logic [3:0] s_axi_wstrb = 4'hF;
logic [1:0] s_axi_bresp, s_axi_rresp, power_reset_flags;
logic [12:0] pc_value;
logic [4:0] port_a_direction;
logic [2:0] adc_config_1;
logic [8:0] ev_v = 0;
cb_byte_t core_flags, option_config, port_b_direction, interrupt_control;
cb_byte_t peripheral_irq_enable_1, timer2_period;
int n_fail = 0, cmp_count = 0;
assign {power_on_pulse, external_reset_pin, wdt_timeout, sleep_enter, alu_carry_we,
    alu_sub, alu_carry, alu_zero_we, alu_zero} = ev_v;
cb_bank uut (.*);
always #20 aclk = ~aclk;
// ****
// tasks
// ****
task finish_test;
    $display("fails %0d compares %0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
endtask
task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
        n_fail++;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
endtask
// readiness is sampled at the falling edge so the rising edge acts on settled values
task wr(input logic [7:0] a, input logic [7:0] d);
    logic ta, tw, tb;
    s_axi_awaddr <= {a, 2'b00}; s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1; s_axi_wvalid <= 1;
    forever begin
        @(negedge aclk); ta = s_axi_awvalid && s_axi_awready;
        tw = s_axi_wvalid && s_axi_wready; tb = s_axi_bvalid;
        @(posedge aclk); if (ta) s_axi_awvalid <= 0;
        if (tw) s_axi_wvalid <= 0;
        if (tb) break;
    end
endtask
task rd(input logic [7:0] a, input logic [7:0] e);
    logic ta, tr; logic [31:0] v;
    s_axi_araddr <= {a, 2'b00}; s_axi_arvalid <= 1;
    forever begin
        @(negedge aclk); ta = s_axi_arvalid && s_axi_arready; tr = s_axi_rvalid;
        v = s_axi_rdata;
        @(posedge aclk); if (ta) s_axi_arvalid <= 0;
        if (tr) break;
    end
    chk(v, {24'h0, e});
endtask
task ev(input logic [8:0] v);
    ev_v <= v; @(posedge aclk); ev_v <= 9'h0; @(posedge aclk);
endtask
// ****
// sequence
// ****
initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1; @(posedge aclk);
    rd(8'h92, 8'hFF);
    rd(8'h82, 8'h00);
    rd(8'h85, 8'h1F);
    rd(8'h88, 8'h00);
    rd(8'h9E, 8'h00);
    wr(8'h0B, 8'hA5); rd(8'h8B, 8'hA5); chk(interrupt_control, 8'hA5);
    wr(8'h8C, 8'hFF); rd(8'h8C, 8'h47); chk(peripheral_irq_enable_1, 8'h47);
    wr(8'h9F, 8'hFF); rd(8'h9F, 8'h07); chk(adc_config_1, 3'h7);
    rd(8'h8E, 8'h00); chk(power_reset_flags, 2'h0);
    wr(8'h84, 8'h25); rd(8'h04, 8'h25);
    wr(8'hA5, 8'h5A); wr(8'h84, 8'hA5); rd(8'h80, 8'h5A);
    wr(8'h00, 8'h3C); rd(8'hA5, 8'h3C);
    ev(9'h020); wr(8'h83, 8'h00); rd(8'h83, 8'h10);
    wr(8'h83, 8'h20); rd(8'h05, 8'h1F);
    wr(8'h83, 8'h00); rd(8'h05, 8'h00);
    ev(9'h01B); rd(8'h83, 8'h15);
    wr(8'h8A, 8'hFF); rd(8'h8A, 8'h1F);
    wr(8'h82, 8'h34); @(negedge aclk); chk({19'h0, pc_value}, 32'h1F34);
    @(posedge aclk); wr(8'h86, 8'h00); wr(8'h81, 8'h00);
    wr(8'h83, 8'h20); ev(9'h080);
    rd(8'h86, 8'hFF);
    rd(8'h83, 8'h10);
    rd(8'h81, 8'h00);
    ev(9'h040); ev(9'h100); rd(8'h81, 8'hFF);
    finish_test;
end
initial begin
    #400000; n_fail++; finish_test;
end
endmodule
`default_nettype wire
